// ===== core/dta_top.sv
`include "dta_regs.svh"
// Summary of operation
// - Two alarm channels, each with its own threshold, sample count, source code and mode bit.
// - Static mode compares the chosen source against the threshold.
// - Threshold bit 15 set means greater-than, clear means less-than.
// - Threshold bits 13:0 hold the limit in source format; bit 14 unused.
// - Dynamic mode compares source change over N samples to the limit.
// - Sample count is bits 7:0, where both zero and one mean one sample.
// - Alarms are reported in two flag bits of the diagnostic register.
// - Alarm 2 source code in bits 15:12 picks the data, zero disables.
// - Alarm 1 source code in bits 11:8 uses the same encoding.
// - Configuration bit 7 makes alarm 2 dynamic when set.
// - Configuration bit 6 makes alarm 1 dynamic when set.
// - Configuration bit 4 feeds filtered data to both alarms when set.
// - Configuration bit 2 enables the indicator output when set.
// - Configuration bit 1 makes the indicator active high when set.
// - Configuration bit 0 routes the indicator to line two when set.
module dta_top
	import dta_pkg::*;
(
	input wire logic mclk, // Sample clock, 40 MHz
	input wire logic rst_n, // Sync reset, active low
	input wire logic spi_cs_n, // Serial select pin, active low
	input wire logic spi_sclk, // Serial clock pin
	input wire logic spi_din, // Serial data in pin
	output logic spi_dout, // Serial data out pin
	input wire logic sample_strobe, // New sensor sample, one cycle
	input wire logic [11:0][15:0] raw_src, // Unfiltered sources 1..12
	input wire logic [11:0][15:0] filt_src, // Filtered sources 1..12
	output logic general_line_one_o, // Line one drive level
	output logic general_line_one_oe, // Line one drive enable
	output logic general_line_two_o, // Line two drive level
	output logic general_line_two_oe, // Line two drive enable
	output logic [1:0] diagnostic_flags // Sticky alarm flags
);
	dta_top_state_t s_r, s_nxt;
	logic cs_fall;
	logic sel_act;
	logic ck_rise;
	logic ck_fall;
	logic [15:0] word;
	logic [6:0] wr_addr;
	logic [15:0] rd_data;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic alm_any;
	logic ind_lvl;
	logic [14:0] pick1;
	logic [14:0] pick2;

	dta_chan_if if1 ();
	dta_chan_if if2 ();

	dta_channel u_ch1 (
		.mclk(mclk),
		.rst_n(rst_n),
		.ch(if1.chan)
	);
	dta_channel u_ch2 (
		.mclk(mclk),
		.rst_n(rst_n),
		.ch(if2.chan)
	);

	// Returns {valid, value} for a source code
	function automatic logic [14:0] pick_src(
		input logic [3:0] code,
		input logic filt
	);
		logic [15:0] v;
		logic ok;
		v = 16'h0000;
		ok = (code != `DTA_SRC_OFF) && (code != `DTA_SRC_GAP)
			&& (code <= `DTA_SRC_LAST);
		if (ok) begin
			v = filt ? filt_src[code - 4'h1] : raw_src[code - 4'h1];
		end
		return {ok, v[13:0]};
	endfunction

	// Byte write into a 16-bit register
	function automatic logic [15:0] put_byte(
		input logic [15:0] old,
		input logic hi,
		input logic [7:0] b,
		input logic [15:0] mask
	);
		logic [15:0] n;
		n = hi ? {b, old[7:0]} : {old[15:8], b};
		return n & mask;
	endfunction

	// Source pick per channel, rerun on any source data change
	always_comb begin
		pick2 = pick_src(s_r.ctrl[`DTA_CTL_SRC2],
			s_r.ctrl[`DTA_CTL_FILT]);
		pick1 = pick_src(s_r.ctrl[`DTA_CTL_SRC1],
			s_r.ctrl[`DTA_CTL_FILT]);
	end

	// Register read mux, unmapped reads zero
	always_comb begin
		rd_data = 16'h0000;
		unique case (s_r.rd_addr)
			`DTA_OFF_THR1: rd_data = s_r.thr1;
			`DTA_OFF_THR2: rd_data = s_r.thr2;
			`DTA_OFF_SMP1: rd_data = {8'h00, s_r.smp1};
			`DTA_OFF_SMP2: rd_data = {8'h00, s_r.smp2};
			`DTA_OFF_CTRL: rd_data = s_r.ctrl;
			`DTA_OFF_DIAG: rd_data = {6'h00, s_r.flags, 8'h00};
			default: rd_data = 16'h0000;
		endcase
	end

	// Edge detection on synchronised pins
	assign sel_act = !s_r.cs_s[1];
	assign cs_fall = s_r.cs_d && !s_r.cs_s[1];
	assign ck_rise = !s_r.ck_d && s_r.ck_s[1];
	assign ck_fall = s_r.ck_d && !s_r.ck_s[1];
	assign word = {s_r.shin[14:0], s_r.di_s[1]};
	assign wr_addr = {word[14:9], 1'b0};

	assign flag_set = {if2.alarm, if1.alarm};
	assign alm_any = if1.alarm || if2.alarm;
	assign ind_lvl = s_r.ctrl[`DTA_CTL_IND_POL] ? alm_any : !alm_any;

	// Next state of the whole top level
	always_comb begin
		s_nxt = s_r;
		flag_clr = 2'b00;
		s_nxt.cs_s = {s_r.cs_s[0], spi_cs_n};
		s_nxt.ck_s = {s_r.ck_s[0], spi_sclk};
		s_nxt.di_s = {s_r.di_s[0], spi_din};
		s_nxt.cs_d = s_r.cs_s[1];
		s_nxt.ck_d = s_r.ck_s[1];
		s_nxt.restart = 1'b0;

		// Serial frame handling
		if (cs_fall) begin
			s_nxt.bits = 4'h0;
			s_nxt.shout = rd_data;
			s_nxt.dout = rd_data[15];
			if (s_r.rd_addr == `DTA_OFF_DIAG) begin
				flag_clr = 2'b11;
			end
		end else if (sel_act && ck_rise) begin
			s_nxt.shin = word;
			s_nxt.bits = s_r.bits + 4'h1;
			if (s_r.bits == `DTA_SPI_LAST) begin
				if (word[15]) begin
					unique case (wr_addr)
						`DTA_OFF_THR1: s_nxt.thr1 = put_byte(s_r.thr1,
							word[8], word[7:0], `DTA_THR_MASK);
						`DTA_OFF_THR2: s_nxt.thr2 = put_byte(s_r.thr2,
							word[8], word[7:0], `DTA_THR_MASK);
						`DTA_OFF_SMP1: if (!word[8]) begin
							s_nxt.smp1 = word[7:0];
						end
						`DTA_OFF_SMP2: if (!word[8]) begin
							s_nxt.smp2 = word[7:0];
						end
						`DTA_OFF_CTRL: begin
							s_nxt.ctrl = put_byte(s_r.ctrl,
								word[8], word[7:0], `DTA_CTL_MASK);
							s_nxt.restart = 1'b1;
						end
						default: s_nxt.restart = 1'b0;
					endcase
				end else begin
					s_nxt.rd_addr = wr_addr;
				end
			end
		end else if (sel_act && ck_fall && s_r.bits != 4'h0) begin
			s_nxt.shout = {s_r.shout[14:0], 1'b0};
			s_nxt.dout = s_r.shout[14];
		end

		// Sticky flags, a new alarm beats the read clear
		s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;

		// Per-sample source values to channels
		s_nxt.strobe = sample_strobe;
		s_nxt.en1 = pick1[14];
		s_nxt.en2 = pick2[14];
		s_nxt.val1 = pick1[13:0];
		s_nxt.val2 = pick2[13:0];

		s_nxt.l1_oe = s_r.ctrl[`DTA_CTL_IND_EN]
			&& !s_r.ctrl[`DTA_CTL_IND_SEL];
		s_nxt.l2_oe = s_r.ctrl[`DTA_CTL_IND_EN]
			&& s_r.ctrl[`DTA_CTL_IND_SEL];
		s_nxt.l1_o = s_nxt.l1_oe && ind_lvl;
		s_nxt.l2_o = s_nxt.l2_oe && ind_lvl;
	end

	// State register, idle pins after reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.cs_s <= 2'b11;
			s_r.ck_s <= 2'b11;
			s_r.cs_d <= 1'b1;
			s_r.ck_d <= 1'b1;
			s_r.thr1 <= `DTA_RST_REG;
			s_r.thr2 <= `DTA_RST_REG;
			s_r.ctrl <= `DTA_RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Channel 1 settings
	assign if1.en = s_r.en1;
	assign if1.dynamic = s_r.ctrl[`DTA_CTL_DYN1];
	assign if1.gt = s_r.thr1[`DTA_THR_DIR];
	assign if1.thr = s_r.thr1[`DTA_THR_VAL];
	assign if1.cnt = s_r.smp1[`DTA_SMP_CNT];
	assign if1.value = s_r.val1;
	assign if1.strobe = s_r.strobe;
	assign if1.restart = s_r.restart;

	// Channel 2 settings
	assign if2.en = s_r.en2;
	assign if2.dynamic = s_r.ctrl[`DTA_CTL_DYN2];
	assign if2.gt = s_r.thr2[`DTA_THR_DIR];
	assign if2.thr = s_r.thr2[`DTA_THR_VAL];
	assign if2.cnt = s_r.smp2[`DTA_SMP_CNT];
	assign if2.value = s_r.val2;
	assign if2.strobe = s_r.strobe;
	assign if2.restart = s_r.restart;

	// Outputs straight from flops
	assign spi_dout = s_r.dout;
	assign general_line_one_o = s_r.l1_o;
	assign general_line_one_oe = s_r.l1_oe;
	assign general_line_two_o = s_r.l2_o;
	assign general_line_two_oe = s_r.l2_oe;
	assign diagnostic_flags = s_r.flags;

	property p_flag1;
		@(posedge mclk) disable iff (!rst_n)
		if1.alarm |=> diagnostic_flags[0];
	endproperty
	a_flag1: assert property (p_flag1)
		else $error("alarm 1 flag not set");

	property p_flag2;
		@(posedge mclk) disable iff (!rst_n)
		(if2.alarm && cs_fall && s_r.rd_addr == `DTA_OFF_DIAG)
		|=> diagnostic_flags[1];
	endproperty
	a_flag2: assert property (p_flag2)
		else $error("alarm 2 flag lost on read clear");

	property p_ind_off;
		@(posedge mclk) disable iff (!rst_n)
		!s_r.ctrl[`DTA_CTL_IND_EN] |=> !general_line_one_oe
		&& !general_line_two_oe;
	endproperty
	a_ind_off: assert property (p_ind_off)
		else $error("indicator driven while disabled");

	property p_pol;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_IND_EN] && !s_r.ctrl[`DTA_CTL_IND_SEL])
		|=> general_line_one_o == ($past(alm_any)
		== $past(s_r.ctrl[`DTA_CTL_IND_POL]));
	endproperty
	a_pol: assert property (p_pol)
		else $error("indicator level has wrong polarity");

	property p_route;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_IND_EN] && s_r.ctrl[`DTA_CTL_IND_SEL])
		|=> general_line_two_oe && !general_line_one_oe;
	endproperty
	a_route: assert property (p_route)
		else $error("indicator on wrong line");

	property p_src_gap;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_SRC2] == `DTA_SRC_GAP
		|| s_r.ctrl[`DTA_CTL_SRC2] > `DTA_SRC_LAST) |=> !if2.en;
	endproperty
	a_src_gap: assert property (p_src_gap)
		else $error("unlisted source code left alarm 2 enabled");

	property p_raw2;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_SRC2] == 4'h3 && !s_r.ctrl[`DTA_CTL_FILT])
		|=> if2.value == $past(raw_src[2][13:0]);
	endproperty
	a_raw2: assert property (p_raw2)
		else $error("alarm 2 got wrong source data");

	property p_filt1;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_SRC1] == 4'h5 && s_r.ctrl[`DTA_CTL_FILT])
		|=> if1.value == $past(filt_src[4][13:0]);
	endproperty
	a_filt1: assert property (p_filt1)
		else $error("alarm 1 did not get filtered data");

	property p_thr_rsv;
		@(posedge mclk) disable iff (!rst_n)
		!s_r.thr1[14] && !s_r.thr2[14];
	endproperty
	a_thr_rsv: assert property (p_thr_rsv)
		else $error("unused threshold bit held a one");

	property p_diag_rd;
		@(posedge mclk) disable iff (!rst_n)
		(cs_fall && s_r.rd_addr == `DTA_OFF_DIAG)
		|=> s_r.shout[9:8] == $past(diagnostic_flags);
	endproperty
	a_diag_rd: assert property (p_diag_rd)
		else $error("flag read returned wrong bits");

	property p_line2;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.ctrl[`DTA_CTL_IND_EN] && s_r.ctrl[`DTA_CTL_IND_SEL]
		&& s_r.ctrl[`DTA_CTL_IND_POL])
		|=> general_line_two_o == $past(if1.alarm || if2.alarm);
	endproperty
	a_line2: assert property (p_line2)
		else $error("line two does not follow the alarms");

	property p_restart;
		@(posedge mclk) disable iff (!rst_n)
		s_r.restart |=> !if1.alarm && !if2.alarm;
	endproperty
	a_restart: assert property (p_restart)
		else $error("alarm kept across a configuration write");

	c_static: cover property (@(posedge mclk) disable iff (!rst_n)
		!if1.dynamic && $rose(if1.alarm));
	c_line2: cover property (@(posedge mclk) disable iff (!rst_n)
		general_line_two_oe && general_line_two_o);
	c_write: cover property (@(posedge mclk) disable iff (!rst_n)
		s_r.restart);
endmodule // dta_top

// ===== core/dta_regs.svh
`ifndef DTA_REGS_SVH
`define DTA_REGS_SVH
// Register offsets on the serial port
`define DTA_OFF_THR1 7'h44
`define DTA_OFF_THR2 7'h46
`define DTA_OFF_SMP1 7'h48
`define DTA_OFF_SMP2 7'h4A
`define DTA_OFF_CTRL 7'h4C
`define DTA_OFF_DIAG 7'h3C
// Reset value and writable masks
`define DTA_RST_REG 16'h0000
`define DTA_THR_MASK 16'hBFFF
`define DTA_CTL_MASK 16'hFFD7
// Field positions
`define DTA_THR_DIR 15
`define DTA_THR_VAL 13:0
`define DTA_SMP_CNT 7:0
`define DTA_CTL_SRC2 15:12
`define DTA_CTL_SRC1 11:8
`define DTA_CTL_DYN2 7
`define DTA_CTL_DYN1 6
`define DTA_CTL_FILT 4
`define DTA_CTL_IND_EN 2
`define DTA_CTL_IND_POL 1
`define DTA_CTL_IND_SEL 0
`define DTA_DIAG_ALM1 8
`define DTA_DIAG_ALM2 9
// Source codes and serial frame length
`define DTA_SRC_OFF 4'h0
`define DTA_SRC_GAP 4'h8
`define DTA_SRC_LAST 4'hC
`define DTA_SPI_LAST 4'hF
`define DTA_HIST_FULL 9'h100
`endif

// ===== core/dta_pkg.sv
package dta_pkg;
	typedef enum logic {CH_IDLE, CH_LOOK} dta_phase_t;

	// State of one alarm channel
	typedef struct packed {
		dta_phase_t phase;
		logic [7:0] ptr;
		logic [8:0] fill;
		logic [13:0] cur;
		logic alarm;
	} dta_ch_state_t;

	// State of the top level
	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] ck_s;
		logic [1:0] di_s;
		logic cs_d;
		logic ck_d;
		logic [3:0] bits;
		logic [15:0] shin;
		logic [15:0] shout;
		logic [6:0] rd_addr;
		logic [15:0] thr1;
		logic [15:0] thr2;
		logic [7:0] smp1;
		logic [7:0] smp2;
		logic [15:0] ctrl;
		logic [1:0] flags;
		logic strobe;
		logic restart;
		logic en1;
		logic en2;
		logic [13:0] val1;
		logic [13:0] val2;
		logic dout;
		logic l1_o;
		logic l1_oe;
		logic l2_o;
		logic l2_oe;
	} dta_top_state_t;
endpackage

// ===== core/dta_chan_if.sv
interface dta_chan_if;
	logic en;
	logic dynamic;
	logic gt;
	logic [13:0] thr;
	logic [7:0] cnt;
	logic [13:0] value;
	logic strobe;
	logic restart;
	logic alarm;
	modport ctl (output en, dynamic, gt, thr, cnt, value, strobe, restart,
		input alarm);
	modport chan (input en, dynamic, gt, thr, cnt, value, strobe, restart,
		output alarm);
endinterface

// ===== core/dta_hist_mem.sv
module dta_hist_mem #(
	parameter int W = 14,
	parameter int D = 256
) (
	input wire logic mclk, // Sample clock
	input wire logic wr_en, // Write strobe
	input wire logic [$clog2(D)-1:0] wr_addr, // Write address
	input wire logic [W-1:0] wr_data, // Write data
	input wire logic [$clog2(D)-1:0] rd_addr, // Read address
	output logic [W-1:0] rd_data // Registered read data
);
	logic [W-1:0] mem [D];

	// Write port and registered read port
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // dta_hist_mem

// ===== core/dta_channel.sv
`include "dta_regs.svh"
module dta_channel
	import dta_pkg::*;
(
	input wire logic mclk, // Sample clock
	input wire logic rst_n, // Sync reset, active low
	dta_chan_if.chan ch // Settings in, alarm out
);
	dta_ch_state_t s_r, s_nxt;
	logic [7:0] span;
	logic [7:0] rd_addr;
	logic [13:0] old_val;
	logic signed [14:0] delta;
	logic [14:0] mag;
	logic hit_static;
	logic hit_dyn;

	assign span = (ch.cnt < 8'h02) ? 8'h01 : ch.cnt;
	assign rd_addr = s_r.ptr - span;

	// History of past samples
	dta_hist_mem #(.W(14), .D(256)) u_hist (
		.mclk(mclk),
		.wr_en(s_r.phase == CH_LOOK),
		.wr_addr(s_r.ptr),
		.wr_data(s_r.cur),
		.rd_addr(rd_addr),
		.rd_data(old_val)
	);

	assign hit_static = ch.gt ? ($signed(ch.value) > $signed(ch.thr))
		: ($signed(ch.value) < $signed(ch.thr));
	assign delta = $signed({s_r.cur[13], s_r.cur})
		- $signed({old_val[13], old_val});
	assign mag = delta[14] ? 15'(-delta) : 15'(delta);
	assign hit_dyn = ch.gt ? (mag > {1'b0, ch.thr}) : (mag < {1'b0, ch.thr});

	// Next state
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.phase)
			CH_IDLE: begin
				if (ch.strobe) begin
					s_nxt.cur = ch.value;
					if (ch.dynamic) begin
						s_nxt.phase = CH_LOOK;
					end else begin
						s_nxt.alarm = ch.en && hit_static;
					end
				end
			end
			CH_LOOK: begin
				s_nxt.phase = CH_IDLE;
				s_nxt.ptr = s_r.ptr + 8'h01;
				if (s_r.fill != `DTA_HIST_FULL) begin
					s_nxt.fill = s_r.fill + 9'h001;
				end
				s_nxt.alarm = ch.en && (s_r.fill >= {1'b0, span}) && hit_dyn;
			end
		endcase
		if (ch.restart) begin
			s_nxt.phase = CH_IDLE;
			s_nxt.fill = 9'h000;
			s_nxt.alarm = 1'b0;
		end
		if (!ch.en) begin
			s_nxt.alarm = 1'b0;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ch.alarm = s_r.alarm;

	property p_static_gt;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.phase == CH_IDLE && ch.strobe && ch.en && !ch.dynamic && ch.gt
		&& !ch.restart && $signed(ch.value) > $signed(ch.thr)) |=> ch.alarm;
	endproperty
	a_static_gt: assert property (p_static_gt)
		else $error("static greater-than alarm missed");

	property p_static_lt;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.phase == CH_IDLE && ch.strobe && ch.en && !ch.dynamic && !ch.gt
		&& !ch.restart) |=> (ch.alarm == ($signed($past(ch.value))
		< $signed($past(ch.thr))));
	endproperty
	a_static_lt: assert property (p_static_lt)
		else $error("static less-than result wrong");

	property p_off;
		@(posedge mclk) disable iff (!rst_n)
		!ch.en |=> !ch.alarm;
	endproperty
	a_off: assert property (p_off)
		else $error("alarm raised on disabled source");

	property p_dyn_seq;
		@(posedge mclk) disable iff (!rst_n)
		(s_r.phase == CH_IDLE && ch.strobe && ch.dynamic && !ch.restart)
		|=> (s_r.phase == CH_LOOK) ##1 (s_r.phase == CH_IDLE);
	endproperty
	a_dyn_seq: assert property (p_dyn_seq)
		else $error("dynamic compare step out of order");

	c_dyn_alarm: cover property (@(posedge mclk) disable iff (!rst_n)
		ch.dynamic && $rose(ch.alarm));
endmodule // dta_channel

// ===== tb/dta_host.sv
// Serial host driving the register port in mode 3
module dta_host (
	input wire logic mclk, // Sample clock
	output logic cs_n, // Select, active low
	output logic sclk, // Serial clock, idle high
	output logic din, // Data towards the device
	input wire logic dout // Data from the device
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle pins at time zero
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end

	// Wait whole cycles, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One 16-bit frame; each bit is caught just before the rise
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		cs_n = 1'b0;
		wt(6);
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			wt(4);
			rx[i] = dout;
			sclk = 1'b1;
			wt(4);
		end
		cs_n = 1'b1;
		din = ~din; // Not selected, so no stale level
		wt(8);
	endtask

	// Register write as two byte frames
	task automatic wr16(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] d;
		xfer({1'b1, a, v[7:0]}, d);
		xfer({1'b1, a + 7'h01, v[15:8]}, d);
	endtask

	// Register read; data returns in the following frame
	task automatic rd16(input logic [6:0] a, output logic [15:0] v);
		logic [15:0] d;
		xfer({1'b0, a, 8'h00}, d);
		xfer(16'h0000, v);
	endtask
endmodule // dta_host

// ===== tb/dta_top_tb.sv
`include "dta_regs.svh"
`define DTA_CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("Error %0t: value %h, expected %h", $time, (g), (e)); \
	end \
end
module dta_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic strobe = 1'b0;
	logic [11:0][15:0] raw = '0;
	logic [11:0][15:0] filt = '0;
	logic cs_n, sclk, din, dout;
	logic l1_o, l1_oe, l2_o, l2_oe;
	logic [1:0] flags;
	int failures = 0;
	int samples_checked = 0;

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	dta_host i_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout));
	dta_top i_dut (.mclk(mclk), .rst_n(rst_n), .spi_cs_n(cs_n),
		.spi_sclk(sclk), .spi_din(din), .spi_dout(dout),
		.sample_strobe(strobe), .raw_src(raw), .filt_src(filt),
		.general_line_one_o(l1_o), .general_line_one_oe(l1_oe),
		.general_line_two_o(l2_o), .general_line_two_oe(l2_oe),
		.diagnostic_flags(flags));

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One sample on every source, then let the result settle
	task automatic fire(input logic [15:0] r, input logic [15:0] f);
		raw = {12{r}};
		filt = {12{f}};
		strobe = 1'b1;
		tick(1);
		strobe = 1'b0;
		tick(6);
	endtask

	// Reset values, writable bits and an unmapped place
	task automatic t_regs();
		logic [6:0] a [6] = '{`DTA_OFF_THR1, `DTA_OFF_THR2, `DTA_OFF_SMP1,
			`DTA_OFF_SMP2, `DTA_OFF_CTRL, 7'h50};
		logic [15:0] m [6] = '{16'hBFFF, 16'hBFFF, 16'h00FF, 16'h00FF,
			16'hFFD7, 16'h0000};
		logic [15:0] d;
		for (int i = 0; i < 6; i++) begin
			i_host.rd16(a[i], d);
			`DTA_CHK(d, 16'h0000) // reset value
			i_host.wr16(a[i], 16'hFFFF);
			i_host.rd16(a[i], d);
			`DTA_CHK(d, m[i]) // unused bits read zero
			i_host.wr16(a[i], 16'h0000);
		end
	endtask

	// Every source code on both alarms, then the filtered pick
	task automatic t_codes();
		logic [15:0] c;
		logic e;
		i_host.wr16(`DTA_OFF_THR1, 16'h8100);
		i_host.wr16(`DTA_OFF_THR2, 16'h8100);
		for (int ch = 0; ch < 2; ch++) begin
			for (int k = 0; k < 16; k++) begin
				c = ch ? {k[3:0], 12'h007} : {4'h0, k[3:0], 8'h06};
				e = (k != 0) && (k != 8) && (k <= 12);
				i_host.wr16(`DTA_OFF_CTRL, c);
				fire(16'h0200, 16'h0000);
				`DTA_CHK(ch ? l2_o : l1_o, e) // source code
				`DTA_CHK({l2_oe, l1_oe}, ch ? 2'b10 : 2'b01) // line
			end
		end
		`DTA_CHK(flags, 2'b11) // flag per alarm
		for (int f = 0; f < 2; f++) begin
			i_host.wr16(`DTA_OFF_CTRL, f ? 16'h0516 : 16'h0506);
			fire(16'h0200, 16'h0000);
			`DTA_CHK(l1_o, f ? 1'b0 : 1'b1) // raw data used
			fire(16'h0000, 16'h0200);
			`DTA_CHK(l1_o, f ? 1'b1 : 1'b0) // filtered data used
		end
	endtask

	// Less-than, low polarity, sticky flags, indicator disable
	task automatic t_static();
		logic [15:0] d;
		i_host.wr16(`DTA_OFF_THR1, 16'h0100);
		i_host.wr16(`DTA_OFF_CTRL, 16'h0204);
		i_host.rd16(`DTA_OFF_DIAG, d);
		`DTA_CHK(d, 16'h0300) // both flags reported
		`DTA_CHK(flags, 2'b00) // cleared by reading
		fire(16'h3F00, 16'h0000);
		`DTA_CHK({l1_oe, l1_o, flags}, 4'b1001) // below
		fire(16'h0100, 16'h0000);
		`DTA_CHK(l1_o, 1'b1) // equal is not below
		i_host.rd16(`DTA_OFF_DIAG, d);
		`DTA_CHK(d, 16'h0100) // lower flag held
		`DTA_CHK(flags, 2'b00) // cleared by reading
		i_host.wr16(`DTA_OFF_CTRL, 16'h0200);
		fire(16'h3F00, 16'h0000);
		`DTA_CHK({l2_oe, l1_oe, flags}, 4'b0001) // indicator off
	endtask

	// Ramp of 8 per sample; alarm only once N samples are held
	task automatic t_dyn(input int ch, input int cnt);
		int n;
		logic [15:0] v;
		logic [15:0] d;
		n = (cnt < 2) ? 1 : cnt;
		i_host.wr16(ch ? `DTA_OFF_THR2 : `DTA_OFF_THR1,
			16'h8000 | 16'(8 * n - 1));
		i_host.wr16(ch ? `DTA_OFF_SMP2 : `DTA_OFF_SMP1, 16'(cnt));
		i_host.wr16(`DTA_OFF_CTRL, ch ? 16'h3087 : 16'h0346);
		for (int k = 0; k <= n; k++) begin
			v = 16'h1000 + 16'(8 * k);
			fire(v, 16'h2000);
			`DTA_CHK(ch ? l2_o : l1_o, k == n) // change
		end
		// Flag read while the alarm still stands
		i_host.rd16(`DTA_OFF_DIAG, d);
		`DTA_CHK({d[8 + ch], flags[ch]}, 2'b11) // set beats clear
	endtask

	// Dynamic less-than: a flat source alarms once two samples are held
	task automatic t_dyn_lt();
		i_host.wr16(`DTA_OFF_THR1, 16'h0004);
		i_host.wr16(`DTA_OFF_SMP1, 16'h0002);
		i_host.wr16(`DTA_OFF_CTRL, 16'h0346);
		for (int k = 0; k < 3; k++) begin
			fire(16'h1000, 16'h0000);
			`DTA_CHK(l1_o, k == 2) // change below limit
		end
	endtask

	// Counts, verdict and end of run
	task automatic conclude();
		$display("Checks %0d, errors %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		tick(5);
		rst_n = 1'b1;
		tick(4);
		`DTA_CHK({l1_oe, l2_oe, flags}, 4'b0000) // quiet after reset
		t_regs();
		t_codes();
		t_static();
		t_dyn(0, 0);
		t_dyn(0, 1);
		t_dyn_lt();
		t_dyn(1, 3);
		t_dyn(1, 255);
		conclude();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge mclk);
		failures++;
		conclude();
	end
endmodule // dta_top_tb
